// ### dchp_pkg.sv
//
// Summary of operation
// - board select from address bits 7:2, default d0
// - base port command/status, base+1 buffer data
// - dormant after reset; phantom asserted for boot
// - prom: microcode low half, bootstrap high half
// - zero command initialises, then phantom released
// - command write to base port is captured
// - status read at base port returns status
// - interrupt mode raises request on completion
// - non-disk command with bit 6 clears interrupt
// - status bit 7 set acknowledges command receipt
// - bit 7 clears after zero command and execution
// - error codes 05, 0b, 0f in status
// - fault detail byte at base+1 after fault
// - zero status after disk command means success
// - disk data passes 1k buffer, programmed bytes
// - selection 00 points at parameter block start
// - selection 01 points at data area, byte eight
// - selection 10 user pointer, 11 indirect through it
// - first buffer byte after read command invalid
// - interrupt on one vectored line, default two
package dchp_pkg;

	localparam int DATA_W     = 8;
	localparam int RAM_DEPTH  = 1024;
	localparam int PROM_DEPTH = 2048;
	localparam int IRQ_LINES  = 8;

	localparam logic [5:0] BASE_DEFAULT = 6'h34;
	localparam logic       PORT_CMD     = 1'h0;
	localparam logic       PORT_DATA    = 1'h1;

	// buffer start locations
	localparam logic [9:0] AREA_PARAM = 10'h000;
	localparam logic [9:0] AREA_DATA  = 10'h008;
	localparam logic [9:0] AREA_UPTR  = 10'h3fe;

	localparam logic [7:0] ERR_NONE      = 8'h00;
	localparam logic [7:0] ERR_NOT_READY = 8'h05;
	localparam logic [7:0] ERR_WPROT     = 8'h0b;
	localparam logic [7:0] ERR_FAULT     = 8'h0f;

	localparam logic [2:0] OP_BUF_WR  = 3'h3;
	localparam logic [2:0] OP_BUF_RD  = 3'h1;
	localparam logic [2:0] OP_DISK_WR = 3'h4;
	localparam logic [2:0] OP_DISK_RD = 3'h2;
	localparam logic [2:0] OP_RESTORE = 3'h1;

	typedef struct packed {
		logic       irq_mode;
		logic       clr_irq;
		logic [1:0] buf_sel;
		logic [2:0] op;
		logic       is_disk;
	} dchp_cmd_s;

	// drive status reported by the disk engine at completion
	typedef struct packed {
		logic not_ready;
		logic write_prot;
		logic check_code_error_flag;
		logic cylinder_timeout_flag;
		logic seek_error_flag;
		logic drive_fault_flag;
	} dchp_dstat_s;

	typedef struct packed {
		logic transfer_complete_flag;
		logic check_code_error_flag;
		logic write_prot_flag;
		logic address_mark_flag;
		logic unit_ready_flag;
		logic cylinder_timeout_flag;
		logic seek_error_flag;
		logic drive_fault_flag;
	} dchp_fault_s;

	typedef enum logic [1:0] {
		ST_DORMANT,
		ST_IDLE,
		ST_DISK,
		ST_DONE
	} dchp_state_e;

endpackage

// ### dchp_fifo.sv
module dchp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  almost_full_out,
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
			$error("fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_out    = cnt_q != (AW+1)'(DEPTH);
	assign almost_full_out = cnt_q >= (AW+1)'(DEPTH - 1);
	assign out_valid_out   = cnt_q != '0;
	assign out_data_out    = mem_q[rd_q];
	assign push            = in_valid_in & in_ready_out;
	assign pop             = out_valid_out & out_ready_in;

	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= rd_q + AW'(1);
			end
			if (push != pop) begin
				cnt_q <= push ? cnt_q + (AW+1)'(1) : cnt_q - (AW+1)'(1);
			end
		end
	end

endmodule

// ### dchp_host_port.sv
module dchp_host_port #(
	parameter int IRQ_LINE   = 2,
	parameter int FIFO_DEPTH = 4,
	parameter logic [7:0] PROM_IMAGE [dchp_pkg::PROM_DEPTH] = '{default: 8'h00}
) (
	input  wire logic                core_clk_in,
	input  wire logic                rst_n_in,
	input  wire logic [7:0]          io_addr_in,
	input  wire logic                io_wr_in,
	input  wire logic                io_rd_in,
	input  wire logic [7:0]          io_wdata_in,
	input  wire logic                mem_rd_in,
	input  wire logic [9:0]          mem_addr_in,
	input  wire logic [5:0]          board_base_in,
	input  wire logic                boot_enable_in,
	input  wire logic                disk_done_in,
	input  wire dchp_pkg::dchp_dstat_s disk_stat_in,
	output logic [7:0]               io_rdata_out,
	output logic [7:0]               mem_rdata_out,
	output logic                     io_busy_out,
	output logic                     phantom_out,
	output logic [7:0]               irq_out,
	output logic                     disk_req_out,
	output dchp_pkg::dchp_cmd_s      disk_cmd_out
);

	generate
		if (IRQ_LINE < 0 || IRQ_LINE >= dchp_pkg::IRQ_LINES) begin : g_bad_irq
			$error("interrupt line out of range");
		end
	endgenerate

	// ****************************************
	// host port decode
	// ****************************************

	logic sel;
	logic cmd_wr;
	logic stat_rd;
	logic data_wr;
	logic data_rd;

	// the two upper ports of the four-port block are left unanswered
	assign sel     = io_addr_in[7:2] == board_base_in && !io_addr_in[1];
	assign cmd_wr  = sel && io_wr_in && io_addr_in[0] == dchp_pkg::PORT_CMD;
	assign stat_rd = sel && io_rd_in && io_addr_in[0] == dchp_pkg::PORT_CMD;
	assign data_wr = sel && io_wr_in && io_addr_in[0] == dchp_pkg::PORT_DATA;
	assign data_rd = sel && io_rd_in && io_addr_in[0] == dchp_pkg::PORT_DATA;

	// ****************************************
	// command register and sequencer
	// ****************************************

	logic [7:0]            cmd_q;
	dchp_pkg::dchp_cmd_s   cmd;
	dchp_pkg::dchp_state_e state_q;
	logic                  ack_q;
	logic [7:0]            code_q;
	dchp_pkg::dchp_fault_s fault_q;
	logic                  fview_q;
	logic                  irq_q;
	logic                  fifo_out_v;
	logic                  go;
	logic                  load;
	logic                  irq_set;
	logic                  disk_req_q;
	dchp_pkg::dchp_cmd_s   disk_cmd_q;
	logic                  zero_wr;
	logic [7:0]            err_code;

	assign cmd     = dchp_pkg::dchp_cmd_s'(cmd_q);
	assign zero_wr = cmd_wr && io_wdata_in == 8'h00;
	// a new command waits until buffered writes have landed
	assign go      = state_q == dchp_pkg::ST_IDLE && cmd_q != 8'h00 && !fifo_out_v;
	assign load    = go && !cmd.is_disk;
	// the host withdraws a disk command before it completes, so use the latched copy
	assign irq_set = (load && cmd.irq_mode)
			|| (state_q == dchp_pkg::ST_DISK && disk_done_in && disk_cmd_q.irq_mode);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_q <= 8'h00;
		end else if (cmd_wr) begin
			cmd_q <= io_wdata_in;
		end
	end

	always_comb begin
		err_code = dchp_pkg::ERR_NONE;
		if (disk_stat_in.not_ready) begin
			err_code = dchp_pkg::ERR_NOT_READY;
		end else if (disk_stat_in.write_prot && disk_cmd_q.op != dchp_pkg::OP_DISK_RD
				&& disk_cmd_q.op != dchp_pkg::OP_RESTORE) begin
			err_code = dchp_pkg::ERR_WPROT;
		end else if (disk_stat_in.drive_fault_flag || disk_stat_in.seek_error_flag
				|| disk_stat_in.cylinder_timeout_flag
				|| disk_stat_in.check_code_error_flag) begin
			err_code = dchp_pkg::ERR_FAULT;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= dchp_pkg::ST_DORMANT;
		end else begin
			unique case (state_q)
				dchp_pkg::ST_DORMANT: begin
					if (zero_wr) begin
						state_q <= dchp_pkg::ST_IDLE;
					end
				end
				dchp_pkg::ST_IDLE: begin
					if (go) begin
						state_q <= cmd.is_disk ? dchp_pkg::ST_DISK : dchp_pkg::ST_DONE;
					end
				end
				dchp_pkg::ST_DISK: begin
					if (disk_done_in) begin
						state_q <= dchp_pkg::ST_DONE;
					end
				end
				dchp_pkg::ST_DONE: begin
					if (cmd_q == 8'h00) begin
						state_q <= dchp_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
		end else if (go) begin
			ack_q <= 1'b1;
		end else if (state_q == dchp_pkg::ST_DONE && cmd_q == 8'h00) begin
			ack_q <= 1'b0;
		end
	end

	// fault detail stays visible at the data port until the next command
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			code_q  <= dchp_pkg::ERR_NONE;
			fault_q <= '0;
			fview_q <= 1'b0;
		end else if (go) begin
			code_q  <= dchp_pkg::ERR_NONE;
			fview_q <= 1'b0;
		end else if (state_q == dchp_pkg::ST_DISK && disk_done_in) begin
			code_q  <= err_code;
			fview_q <= err_code == dchp_pkg::ERR_FAULT;
			fault_q <= '0;
			fault_q.check_code_error_flag <= disk_stat_in.check_code_error_flag;
			fault_q.cylinder_timeout_flag <= disk_stat_in.cylinder_timeout_flag;
			fault_q.seek_error_flag       <= disk_stat_in.seek_error_flag;
			fault_q.drive_fault_flag      <= disk_stat_in.drive_fault_flag;
		end
	end

	// ****************************************
	// disk engine request
	// ****************************************

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			disk_req_q <= 1'b0;
			disk_cmd_q <= '0;
		end else begin
			disk_req_q <= go && cmd.is_disk;
			if (go && cmd.is_disk) begin
				disk_cmd_q <= cmd;
			end
		end
	end

	// ****************************************
	// interrupt
	// ****************************************

	logic [7:0] vi_q;

	// completion sets after the clear so a simultaneous event survives
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_q <= 1'b0;
		end else begin
			if (load && cmd.clr_irq) begin
				irq_q <= 1'b0;
			end
			if (irq_set) begin
				irq_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vi_q <= 8'h00;
		end else begin
			vi_q <= irq_q ? 8'(1 << IRQ_LINE) : 8'h00;
		end
	end

	// ****************************************
	// buffer ram, pointer and write fifo
	// ****************************************

	logic [7:0] ram_q [dchp_pkg::RAM_DEPTH];
	logic [9:0] ptr_q;
	logic [9:0] start;
	logic [9:0] uptr;
	logic [7:0] pre_q;
	logic [7:0] fifo_out_d;
	logic       fifo_rdy;
	logic       fifo_afull;
	logic       drain;

	// a host read owns the ram port, so draining stalls and the fifo fills
	assign drain = fifo_out_v && !data_rd;
	assign uptr  = {ram_q[dchp_pkg::AREA_UPTR + 10'h001][1:0], ram_q[dchp_pkg::AREA_UPTR]};

	always_comb begin
		unique case (cmd.buf_sel)
			2'h0: start = dchp_pkg::AREA_PARAM;
			2'h1: start = dchp_pkg::AREA_DATA;
			2'h2: start = dchp_pkg::AREA_UPTR;
			2'h3: start = uptr;
		endcase
	end

	dchp_fifo #(
		.WIDTH(dchp_pkg::DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.core_clk_in    (core_clk_in),
		.rst_n_in       (rst_n_in),
		.in_valid_in    (data_wr),
		.in_data_in     (io_wdata_in),
		.in_ready_out   (fifo_rdy),
		.almost_full_out(fifo_afull),
		.out_valid_out  (fifo_out_v),
		.out_data_out   (fifo_out_d),
		.out_ready_in   (!data_rd)
	);

	always_ff @(posedge core_clk_in) begin
		if (drain) begin
			ram_q[ptr_q] <= fifo_out_d;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ptr_q <= dchp_pkg::AREA_PARAM;
		end else if (load) begin
			ptr_q <= start;
		end else if (drain || (data_rd && !fview_q)) begin
			ptr_q <= ptr_q + 10'h001;
		end
	end

	// one-deep prefetch: the first byte after a reload is stale
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_q <= 8'h00;
		end else if (data_rd && !fview_q) begin
			pre_q <= ram_q[ptr_q];
		end
	end

	// ****************************************
	// host read data and status
	// ****************************************

	logic [7:0] rdata_q;
	logic [7:0] status;
	logic       busy_q;

	assign status = {ack_q, code_q[6:0]};

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= 8'h00;
		end else if (stat_rd) begin
			rdata_q <= status;
		end else if (data_rd) begin
			rdata_q <= fview_q ? fault_q : pre_q;
		end
	end

	// busy lags one cycle, so it is raised one entry early
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= fifo_afull || !fifo_rdy;
		end
	end

	// ****************************************
	// bootstrap window
	// ****************************************

	logic       phantom_q;
	logic [7:0] mem_q;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phantom_q <= 1'b0;
		end else begin
			phantom_q <= boot_enable_in && state_q == dchp_pkg::ST_DORMANT;
		end
	end

	// microcode lives in the low half and is never visible to the host
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_q <= 8'h00;
		end else if (mem_rd_in && phantom_q) begin
			mem_q <= PROM_IMAGE[{1'b1, mem_addr_in}];
		end
	end

	assign io_rdata_out  = rdata_q;
	assign mem_rdata_out = mem_q;
	assign io_busy_out   = busy_q;
	assign phantom_out   = phantom_q;
	assign irq_out       = vi_q;
	assign disk_req_out  = disk_req_q;
	assign disk_cmd_out  = disk_cmd_q;

	// ****************************************
	// checks
	// ****************************************

	sequence s_accept;
		go;
	endsequence

	sequence s_withdrawn;
		state_q == dchp_pkg::ST_DONE && cmd_q == 8'h00;
	endsequence

	a_ack_on_accept: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		s_accept |=> ack_q && io_busy_out == $past(fifo_afull || !fifo_rdy))
		else $error("acknowledge not set on command accept");

	a_ack_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		s_withdrawn |=> !ack_q && state_q == dchp_pkg::ST_IDLE)
		else $error("acknowledge not released after withdraw");

	a_ack_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		ack_q && state_q != dchp_pkg::ST_DONE |=> ack_q)
		else $error("acknowledge dropped before execution");

	a_dormant_wait: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		state_q == dchp_pkg::ST_DORMANT && !zero_wr |=> state_q == dchp_pkg::ST_DORMANT)
		else $error("left dormant state without zero command");

	a_phantom_drop: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		state_q == dchp_pkg::ST_DORMANT && zero_wr |=> ##1 !phantom_out)
		else $error("phantom not released after initialisation");

	a_error_code: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		state_q == dchp_pkg::ST_DISK && disk_done_in && disk_stat_in.not_ready
		|=> code_q == dchp_pkg::ERR_NOT_READY)
		else $error("drive not ready code missing");

	a_fault_zeros: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		data_rd && fview_q |=> io_rdata_out[7] == 1'b0 && io_rdata_out[5:3] == 3'h0)
		else $error("fault detail reserved bits not zero");

	a_irq_raise: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		irq_set |=> irq_q ##1 irq_out[IRQ_LINE])
		else $error("completion interrupt not raised");

	a_irq_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		irq_q && !(load && cmd.clr_irq) |=> irq_q)
		else $error("interrupt dropped without clear command");

	a_status_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		stat_rd |=> io_rdata_out == $past(status))
		else $error("status read returned wrong byte");

	a_data_start: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		load && cmd.buf_sel == 2'h1 |=> ptr_q == dchp_pkg::AREA_DATA)
		else $error("data area selection wrong start");

endmodule

// ### dchp_host_model.sv
module dchp_host_model (
	input  wire logic       core_clk_in,
	input  wire logic [7:0] io_rdata_in,
	output logic [7:0]      io_addr_out,
	output logic            io_wr_out,
	output logic            io_rd_out,
	output logic [7:0]      io_wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****
	// host bus cycles
	// ****
	initial begin
		io_addr_out = 8'h00;
		io_wr_out = 1'b0;
		io_rd_out = 1'b0;
		io_wdata_out = 8'h00;
	end

	// released data bus shows the inverse, so stale bytes never pass
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(negedge core_clk_in);
		io_addr_out = addr;
		io_wdata_out = data;
		io_wr_out = 1'b1;
		@(negedge core_clk_in);
		io_wr_out = 1'b0;
		io_wdata_out = ~data;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(negedge core_clk_in);
		io_addr_out = addr;
		io_rd_out = 1'b1;
		@(negedge core_clk_in);
		io_rd_out = 1'b0;
		data = io_rdata_in;
	endtask

	// bounded polls: a stuck acknowledge shows up in the returned status
	task automatic handshake(input logic [7:0] cmd, output logic acked, output logic [7:0] st);
		int n;
		acked = 1'b0;
		st = 8'h00;
		wr(8'hd0, cmd);
		for (n = 0; n < 20 && !acked; n++) begin
			rd(8'hd0, st);
			acked = (st[7] === 1'b1);
		end
		wr(8'hd0, 8'h00);
		for (n = 0; n < 50 && st[7] !== 1'b0; n++) begin
			rd(8'hd0, st);
		end
	endtask
endmodule

// ### dchp_host_port_bench.sv
module dchp_host_port_bench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [7:0] cmd;
		logic [5:0] st;
		logic [7:0] code;
		logic [7:0] fb;
	} dchp_row_s;

	localparam logic [7:0] PROM_T [dchp_pkg::PROM_DEPTH] = '{1029: 8'h5a, default: 8'h00};

	logic                  core_clk_in = 1'b0;
	logic                  rst_n_in = 1'b0;
	logic [7:0]            io_addr, io_wdata, io_rdata, mem_rdata, irq, v;
	logic                  io_wr, io_rd, busy, phantom, disk_req, acked;
	logic                  mem_rd = 1'b0;
	logic [9:0]            mem_addr = 10'h000;
	logic                  disk_done = 1'b0;
	dchp_pkg::dchp_dstat_s disk_stat = '0;
	dchp_pkg::dchp_cmd_s   disk_cmd;
	int                    errors = 0;
	int                    compares = 0;
	int                    cycles = 0;
	int                    dly = 0;
	dchp_row_s             rows [6] = '{
		'{8'h19, 6'h00, 8'h00, 8'h00},
		'{8'h19, 6'h21, 8'h05, 8'h00},
		'{8'h99, 6'h10, 8'h0b, 8'h00},
		'{8'h15, 6'h10, 8'h00, 8'h00},
		'{8'h95, 6'h02, 8'h0f, 8'h02},
		'{8'h19, 6'h09, 8'h0f, 8'h41}
	};
	logic [7:0]            ld [10] = '{8'h08, 8'h01, 8'h05, 8'h02, 8'h34, 8'h01,
		8'h00, 8'h00, 8'ha5, 8'h5a};

	initial begin
		forever #10 core_clk_in = ~core_clk_in;
	end

	dchp_host_port #(.IRQ_LINE(2), .FIFO_DEPTH(4), .PROM_IMAGE(PROM_T)) dchp_host_port_inst (
		.core_clk_in   (core_clk_in),
		.rst_n_in      (rst_n_in),
		.io_addr_in    (io_addr),
		.io_wr_in      (io_wr),
		.io_rd_in      (io_rd),
		.io_wdata_in   (io_wdata),
		.mem_rd_in     (mem_rd),
		.mem_addr_in   (mem_addr),
		.board_base_in (6'h34),
		.boot_enable_in(1'b1),
		.disk_done_in  (disk_done),
		.disk_stat_in  (disk_stat),
		.io_rdata_out  (io_rdata),
		.mem_rdata_out (mem_rdata),
		.io_busy_out   (busy),
		.phantom_out   (phantom),
		.irq_out       (irq),
		.disk_req_out  (disk_req),
		.disk_cmd_out  (disk_cmd)
	);

	dchp_host_model dchp_host_model_inst (
		.core_clk_in (core_clk_in),
		.io_rdata_in (io_rdata),
		.io_addr_out (io_addr),
		.io_wr_out   (io_wr),
		.io_rd_out   (io_rd),
		.io_wdata_out(io_wdata)
	);

	// ****
	// disk engine stand-in: completes three cycles after each request
	// ****
	always @(negedge core_clk_in) begin
		disk_done <= 1'b0;
		if (dly > 0) begin
			dly <= dly - 1;
			if (dly == 1) begin
				disk_done <= 1'b1;
			end
		end else if (disk_req === 1'b1) begin
			dly <= 3;
		end
	end

	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ****
	// checking and verdict
	// ****
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic bytes_rd(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
		dchp_host_model_inst.handshake(cmd, acked, v);
		chk("buf ack", acked, 8'h01);
		dchp_host_model_inst.rd(8'hd1, v); // stale byte dropped
		dchp_host_model_inst.rd(8'hd1, v);
		chk("buf byte0", v, e0);
		dchp_host_model_inst.rd(8'hd1, v);
		chk("buf byte1", v, e1);
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		repeat (4) @(posedge core_clk_in);
		@(negedge core_clk_in);
		rst_n_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		chk("phantom up", phantom, 8'h01);
		chk("irq reset", irq, 8'h00);
		chk("busy idle", busy, 8'h00);
		mem_addr = 10'h005;
		mem_rd = 1'b1;
		@(negedge core_clk_in);
		mem_rd = 1'b0;
		chk("boot byte", mem_rdata, 8'h5a);
		dchp_host_model_inst.wr(8'hd0, 8'h06);
		repeat (5) @(negedge core_clk_in);
		dchp_host_model_inst.rd(8'hd0, v);
		chk("dormant status", v, 8'h00);
		dchp_host_model_inst.wr(8'hd0, 8'h00);
		repeat (10) @(negedge core_clk_in);
		chk("phantom down", phantom, 8'h00);
		$display("test init done");

		foreach (rows[i]) begin
			disk_stat = rows[i].st;
			dchp_host_model_inst.handshake(rows[i].cmd, acked, v);
			chk("disk ack", acked, 8'h01);
			chk("disk status", v, rows[i].code);
			chk("disk cmd", disk_cmd, rows[i].cmd);
			if (rows[i].code == 8'h0f) begin
				dchp_host_model_inst.rd(8'hd1, v);
				chk("fault byte", v, rows[i].fb);
			end
			repeat (3) @(negedge core_clk_in);
			chk("irq set", irq, rows[i].cmd[7] ? 8'h04 : 8'h00);
			if (rows[i].cmd[7]) begin
				dchp_host_model_inst.handshake(8'h40, acked, v);
				repeat (3) @(negedge core_clk_in);
				chk("irq clear", irq, 8'h00);
			end
			$display("test row %0d done", i);
		end

		// data area, then parameter block, at their buffer starts
		dchp_host_model_inst.handshake(8'h06, acked, v);
		chk("load status", v, 8'h00);
		foreach (ld[i]) begin
			dchp_host_model_inst.wr(8'hd1, ld[i]);
		end
		bytes_rd(8'h12, 8'ha5, 8'h5a);
		bytes_rd(8'h02, 8'h08, 8'h01);
		$display("test buffer areas done");

		dchp_host_model_inst.handshake(8'h26, acked, v);
		dchp_host_model_inst.wr(8'hd1, 8'h20);
		dchp_host_model_inst.wr(8'hd1, 8'h00);
		dchp_host_model_inst.handshake(8'h36, acked, v);
		dchp_host_model_inst.wr(8'hd1, 8'hc3);
		dchp_host_model_inst.wr(8'hd1, 8'h3c);
		bytes_rd(8'h32, 8'hc3, 8'h3c);
		$display("test user pointer done");

		dchp_host_model_inst.rd(8'hd2, v);
		chk("unmapped read", v, 8'h3c);
		dchp_host_model_inst.wr(8'hd4, 8'h06);
		repeat (3) @(negedge core_clk_in);
		dchp_host_model_inst.rd(8'hd0, v);
		chk("foreign port", v, 8'h00);
		$display("test decode done");
		tally_and_finish();
	end
endmodule
